// ==== logic/tmb_map.svh ====
// register offsets, field positions and reset values of the second timer unit
// included by the timer unit design file, which also imports tmb_pkg; definitions only
`ifndef TMB_MAP_SVH
`define TMB_MAP_SVH

`define TMB_OFS_COUNT      4'h9
`define TMB_OFS_CTRL_ONE   4'hA
`define TMB_OFS_CTRL_TWO   4'hB
`define TMB_OFS_DUTY       4'hC
`define TMB_OFS_PRE_COUNT  4'hD
`define TMB_OFS_BUZZER     4'hE

`define TMB_C1_RUN         0
`define TMB_C1_RELOAD      1
`define TMB_C1_ONESHOT     2
`define TMB_C1_ACTLOW      6
`define TMB_C1_PWMEN       7

`define TMB_C2_SEL_LSB     0
`define TMB_C2_BYPASS      3
`define TMB_C2_EDGE        4
`define TMB_C2_SOURCE      5

`define TMB_BZ_EN          7

`define TMB_RST_CTRL_ONE   8'h00
`define TMB_RST_CTRL_TWO   8'h3F
`define TMB_RST_PRE_COUNT  8'hFF
`define TMB_RST_BUZZER     8'h0F
`define TMB_RST_COUNT      8'hFF
`define TMB_RST_DUTY       8'h00

`endif

// ==== logic/tmb_pkg.sv ====
// types shared by the second timer unit
// no constants here; numbers live in tmb_map.svh
package tmb_pkg;
	typedef enum logic [1:0]
	{
		TMB_IDLE,
		TMB_COUNTING,
		TMB_DONE
	} tmb_state_t;
endpackage

// ==== logic/tmb_edge_sync.sv ====
// three-stage synchroniser with rise and fall pulses for the external count pin
// assumes the pin is asynchronous to clock and slower than half its rate
`timescale 1ns/1ns
module tmb_edge_sync
(
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic pinIn,
	output logic      risePulse,
	output logic      fallPulse
);
	logic [2:0] syncReg;

	// stage 0 feeds stage 1 only; edges are judged on stages 1 and 2
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			syncReg <= 3'h0;
		else
			syncReg <= {syncReg[1:0], pinIn};
	end

	assign risePulse = syncReg[1] & ~syncReg[2];
	assign fallPulse = ~syncReg[1] & syncReg[2];
endmodule

// ==== logic/tmb_timer_unit.sv ====
// second 8-bit down-counting timer with prescaler, pwm and buzzer outputs
// registers reached over a plain strobe port; clock is the instruction clock
// Behaviour
// [RULE1] counts only while run bit set
// [RULE2] non-stop, no reload: wraps to all ones
// [RULE3] non-stop with reload: loads reload value
// [RULE4] one-shot counts to zero then stops
// [RULE5] pwm inactive after start until match
// [RULE6] match makes pwm active until underflow
// [RULE7] reload sets period, duty sets width
// [RULE8] duty register write-only, undefined at reset
// [RULE9] polarity bit set gives active-low pwm
// [RULE10] pwm enable routes pwm onto port pin
// [RULE11] prescaler ratio is two to code plus one
// [RULE12] software changes ratio only while bypassed
// [RULE13] bypass bit high skips the prescaler
// [RULE14] edge bit picks falling or rising pin edge
// [RULE15] source bit picks instruction clock or pin
// [RULE16] prescaler count readable, resets to all ones
// [RULE17] buzzer codes 0-7 give prescaler taps
// [RULE18] buzzer codes 8-15 give timer bits
// [RULE19] buzzer enable routes buzzer onto port pin
// [RULE20] count write sets reload and counter
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`include "tmb_map.svh"
module tmb_timer_unit
	import tmb_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic [3:0]       regAddr,
	input  wire logic [7:0]       regWriteData,
	input  wire logic             regWrite,
	input  wire logic             regRead,
	output logic      [7:0]       regReadData,
	input  wire logic             extCountClockPin,
	input  wire logic             portBBitFourGpio,
	input  wire logic             portBBitFiveGpio,
	output logic                  portBBitFour,
	output logic                  portBBitFive,
	output logic                  underflowPulse
);
	logic [7:0]       ctrlOneReg;
	logic [7:0]       ctrlTwoReg;
	logic [7:0]       dutyReg;
	logic [7:0]       buzzerReg;
	logic [WIDTH-1:0] reloadReg;
	logic [WIDTH-1:0] countReg;
	logic [WIDTH-1:0] countNext;
	logic [7:0]       preReg;
	logic             pwmActiveReg;
	logic             pwmActiveNext;
	logic             buzzerReg_q;
	tmb_state_t       stateReg;
	tmb_state_t       stateNext;
	logic             pinRise;
	logic             pinFall;

	tmb_edge_sync u_sync
	(
		.clock     (clock),
		.rst_n     (rst_n),
		.pinIn     (extCountClockPin),
		.risePulse (pinRise),
		.fallPulse (pinFall)
	);

	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = a == ofs;
	endfunction

	wire runBit     = ctrlOneReg[`TMB_C1_RUN];
	wire reloadSel  = ctrlOneReg[`TMB_C1_RELOAD];
	wire oneShot    = ctrlOneReg[`TMB_C1_ONESHOT];
	wire activeLow  = ctrlOneReg[`TMB_C1_ACTLOW];
	wire pwmPinEn   = ctrlOneReg[`TMB_C1_PWMEN];
	wire [2:0] ratioSel = ctrlTwoReg[`TMB_C2_SEL_LSB +: 3];
	wire bypassN    = ctrlTwoReg[`TMB_C2_BYPASS];
	wire edgeSel    = ctrlTwoReg[`TMB_C2_EDGE];
	wire sourceSel  = ctrlTwoReg[`TMB_C2_SOURCE];
	wire [3:0] toneSel = buzzerReg[3:0];
	wire buzzEn     = buzzerReg[`TMB_BZ_EN];

	wire wrCount = regWrite & hit(regAddr, `TMB_OFS_COUNT);
	wire wrOne   = regWrite & hit(regAddr, `TMB_OFS_CTRL_ONE);
	wire wrTwo   = regWrite & hit(regAddr, `TMB_OFS_CTRL_TWO);
	wire wrDuty  = regWrite & hit(regAddr, `TMB_OFS_DUTY);
	wire wrBuzz  = regWrite & hit(regAddr, `TMB_OFS_BUZZER);

	// source tick: instruction clock every cycle or one chosen pin edge
	wire srcTick = sourceSel ? (edgeSel ? pinFall : pinRise) : 1'b1; // see [RULE14] see [RULE15]

	// prescaler free-runs down on source ticks; tap bit k toggles at 1:2^(k+1)
	wire [7:0] preNextVal = preReg - 8'h01;
	wire [7:0] preFlip = preReg & ~preNextVal;
	wire preTap = preFlip[ratioSel] & srcTick; // see [RULE11]
	// a ratio change while inserted can hit a mid-count tap and tick early
	wire timerTick = runBit & (bypassN ? srcTick : preTap); // see [RULE13] see [RULE12] see [RULE1]

	wire atZero    = countReg == '0;
	wire underflow = timerTick & atZero & (stateReg == TMB_COUNTING);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			preReg <= `TMB_RST_PRE_COUNT;
		else if (srcTick)
			preReg <= preNextVal;
	end

	always_comb
	begin
		stateNext = stateReg;
		countNext = countReg;
		case (stateReg)
			TMB_IDLE:
			begin
				if (runBit)
					stateNext = TMB_COUNTING;
			end
			TMB_COUNTING:
			begin
				if (!runBit)
					stateNext = TMB_IDLE; // see [RULE1]
				else if (timerTick)
				begin
					if (!atZero)
						countNext = countReg - 1'b1;
					else if (oneShot)
						stateNext = TMB_DONE; // see [RULE4]
					else if (reloadSel)
						countNext = reloadReg; // see [RULE3] see [RULE7]
					else
						countNext = '1; // see [RULE2]
				end
			end
			TMB_DONE:
			begin
				if (!runBit)
					stateNext = TMB_IDLE;
			end
			default:
				stateNext = TMB_IDLE;
		endcase
		if (wrCount)
		begin
			countNext = regWriteData[WIDTH-1:0]; // see [RULE20]
			if (stateReg == TMB_DONE)
				stateNext = TMB_IDLE;
		end
	end

	// pwm: cleared on start and underflow, set on duty match
	// judged on the next count so the flag stands in the same cycle as the matching count
	always_comb
	begin
		pwmActiveNext = pwmActiveReg;
		if (stateReg == TMB_IDLE)
			pwmActiveNext = 1'b0; // see [RULE5]
		else if (stateNext == TMB_COUNTING && countNext == dutyReg[WIDTH-1:0])
			pwmActiveNext = 1'b1; // see [RULE6] see [RULE7]
		else if (underflow)
			pwmActiveNext = 1'b0; // see [RULE6]
	end

	wire buzzNext = toneSel[3] ? countReg[toneSel[2:0]] : preReg[toneSel[2:0]]; // see [RULE17] see [RULE18]
	wire pwmLevel = pwmActiveReg ^ activeLow; // see [RULE9]

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stateReg     <= TMB_IDLE;
			countReg     <= `TMB_RST_COUNT;
			pwmActiveReg <= 1'b0;
			buzzerReg_q  <= 1'b0;
		end
		else
		begin
			stateReg     <= stateNext;
			countReg     <= countNext;
			pwmActiveReg <= pwmActiveNext;
			buzzerReg_q  <= buzzNext;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrlOneReg <= `TMB_RST_CTRL_ONE;
			ctrlTwoReg <= `TMB_RST_CTRL_TWO;
			buzzerReg  <= `TMB_RST_BUZZER;
			reloadReg  <= `TMB_RST_COUNT;
			dutyReg    <= `TMB_RST_DUTY; // see [RULE8]
		end
		else
		begin
			if (wrOne)
				ctrlOneReg <= regWriteData;
			if (wrTwo)
				ctrlTwoReg <= {2'b00, regWriteData[5:0]};
			if (wrBuzz)
				buzzerReg <= regWriteData;
			if (wrCount)
				reloadReg <= regWriteData[WIDTH-1:0]; // see [RULE20]
			if (wrDuty)
				dutyReg <= regWriteData; // see [RULE8]
		end
	end

	// read mux; write-only registers and pwm bits read as zero
	logic [7:0] readMux;
	always_comb
	begin
		readMux = 8'h00;
		case (regAddr)
			`TMB_OFS_COUNT:     readMux = 8'(countReg); // see [RULE20]
			`TMB_OFS_CTRL_ONE:  readMux = {5'h00, ctrlOneReg[2:0]};
			`TMB_OFS_CTRL_TWO:  readMux = ctrlTwoReg;
			`TMB_OFS_PRE_COUNT: readMux = preReg; // see [RULE16]
			default:            readMux = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			regReadData    <= 8'h00;
			portBBitFour   <= 1'b0;
			portBBitFive   <= 1'b0;
			underflowPulse <= 1'b0;
		end
		else
		begin
			regReadData    <= regRead ? readMux : 8'h00;
			portBBitFour   <= pwmPinEn ? pwmLevel : portBBitFourGpio; // see [RULE10]
			portBBitFive   <= buzzEn ? buzzerReg_q : portBBitFiveGpio; // see [RULE19]
			underflowPulse <= underflow;
		end
	end
endmodule

// ==== dv/tmb_timer_unit_sva.sv ====
// checker for the second timer unit
// sees only top ports; mirrors control writes itself
`timescale 1ns/1ns
module tmb_timer_sva
(
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [7:0] regReadData,
	input wire logic       portBBitFourGpio,
	input wire logic       portBBitFiveGpio,
	input wire logic       portBBitFour,
	input wire logic       portBBitFive,
	input wire logic       underflowPulse
);
	logic [7:0] oneReg;
	logic [7:0] twoReg;
	logic       buzReg;
	logic [1:0] liveReg;
	logic [2:0] offReg;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n)
		begin
			oneReg <= 8'h00;
			twoReg <= 8'h3F;
			buzReg <= 1'b0;
			liveReg <= 2'h0;
			offReg <= 3'h0;
		end
		else
		begin
			if (regWrite && regAddr == 4'hA)
				oneReg <= regWriteData;
			if (regWrite && regAddr == 4'hB)
				twoReg <= regWriteData;
			if (regWrite && regAddr == 4'hE)
				buzReg <= regWriteData[7];
			if (liveReg != 2'h3)
				liveReg <= liveReg + 2'h1;
			// saturate so a long halt stays visible
			offReg <= oneReg[0] ? 3'h0 : (offReg == 3'h7 ? offReg : offReg + 3'h1);
		end
	wo_read_a: assert property (regRead && (regAddr == 4'hC || regAddr == 4'hE) |=> regReadData == 8'h00)
		else $error("write-only register read not zero");
	ctrl_one_a: assert property (regRead && regAddr == 4'hA |=> regReadData == {5'h00, $past(oneReg[2:0])})
		else $error("control one readback wrong");
	ctrl_two_a: assert property (regRead && regAddr == 4'hB |=> regReadData == {2'h0, $past(twoReg[5:0])})
		else $error("control two readback wrong");
	pwm_gpio_a: assert property (liveReg == 2'h3 && !oneReg[7] && $past(!oneReg[7]) |-> portBBitFour == $past(portBBitFourGpio))
		else $error("pin four not following gpio");
	buz_gpio_a: assert property (liveReg == 2'h3 && !buzReg && $past(!buzReg) |-> portBBitFive == $past(portBBitFiveGpio))
		else $error("pin five not following gpio");
	halt_quiet_a: assert property (offReg == 3'h7 |-> !underflowPulse)
		else $error("underflow while halted");
	one_shot_a: assert property (oneReg[2] && oneReg[0] && underflowPulse && !regWrite |=> !underflowPulse)
		else $error("one-shot underflowed again");
	count_back_a: assert property (regWrite && regAddr == 4'h9 && !oneReg[0] ##1 regRead && regAddr == 4'h9
		|=> regReadData == $past(regWriteData, 2))
		else $error("count readback wrong");
endmodule
bind tmb_timer_unit tmb_timer_sva chk (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWriteData(regWriteData),
	.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .portBBitFourGpio(portBBitFourGpio),
	.portBBitFiveGpio(portBBitFiveGpio), .portBBitFour(portBBitFour), .portBBitFive(portBBitFive),
	.underflowPulse(underflowPulse));

// ==== dv/tmb_pin_load.sv ====
// load on the two port pins: counts pwm high cycles and buzzer toggles
// assumes clear is driven by the bench at the clock edge
`timescale 1ns/1ns
module tmb_pin_load
(
	input  wire logic       clock,
	input  wire logic       clear,
	input  wire logic       pwmPin,
	input  wire logic       buzzPin,
	output logic      [7:0] highCount,
	output logic      [7:0] toggleCount
);
	logic lastBuzz;
	always @(posedge clock)
	begin
		lastBuzz <= buzzPin;
		highCount <= clear ? 8'h00 : highCount + {7'h00, pwmPin};
		toggleCount <= clear ? 8'h00 : toggleCount + {7'h00, buzzPin ^ lastBuzz};
	end
endmodule

// ==== dv/tmb_timer_unit_tb_top.sv ====
// self-checking bench for the second timer unit
// assumes the pin load model and bound checker
`timescale 1ns/1ns
module tmb_timer_unit_tb_top;
	logic       clock = 0;
	logic       rst_n = 0;
	logic       regWrite = 0;
	logic       regRead = 0;
	logic       extPin = 0;
	logic       gpioFour = 0;
	logic       gpioFive = 0;
	logic       clear = 1;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWriteData = 8'h00;
	logic [7:0] v;
	wire  [7:0] regReadData;
	wire  [7:0] highCount;
	wire  [7:0] toggleCount;
	wire        pinFour;
	wire        pinFive;
	wire        underflowPulse;
	int         fail_count = 0;
	int         checks_done = 0;
	int         cycles = 0;
	int         i;
	int         e;
	tmb_timer_unit dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWriteData(regWriteData),
		.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .extCountClockPin(extPin),
		.portBBitFourGpio(gpioFour), .portBBitFiveGpio(gpioFive), .portBBitFour(pinFour),
		.portBBitFive(pinFive), .underflowPulse(underflowPulse));
	tmb_pin_load load (.clock(clock), .clear(clear), .pwmPin(pinFour), .buzzPin(pinFive),
		.highCount(highCount), .toggleCount(toggleCount));
	always #5 clock = ~clock;
	always @(posedge clock)
	begin
		gpioFour <= ~gpioFour;
		gpioFive <= cycles[2];
		cycles++;
		// far above the roughly 1100 cycles the tests need
		if (cycles == 10000)
		begin
			fail_count++;
			results;
		end
	end
	task results;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task check(input string n, input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		@(negedge clock);
		v = regReadData;
		@(posedge clock);
	endtask
	task near(input string n, input int got, input int exp);
		check(n, 8'(got >= exp - 2 && got <= exp + 2), 8'h01);
	endtask
	task measure(input int n);
		clear <= 1'b1;
		@(posedge clock);
		clear <= 1'b0;
		repeat (n) @(posedge clock);
	endtask
	task wait_pulse;
		i = 0;
		while (underflowPulse !== 1'b1 && i < 600)
		begin
			@(negedge clock);
			i++;
		end
		@(posedge clock);
		check("underflow seen", 8'(i < 600), 8'h01);
	endtask
	task t_reset;
		rd(4'hD);
		check("prescaler", v, 8'hFF);
		rd(4'h9);
		check("count", v, 8'hFF);
		rd(4'hA);
		check("ctrl one", v, 8'h00);
		rd(4'hB);
		check("ctrl two", v, 8'h3F);
		rd(4'hC);
		check("duty", v, 8'h00);
		rd(4'h0);
		check("unmapped", v, 8'h00);
		$display("reset test done");
	endtask
	task t_modes;
		wr(4'hB, 8'h08);
		wr(4'h9, 8'h5A);
		rd(4'h9);
		check("count write", v, 8'h5A);
		// reload keeps 0x1F in range, wrap restarts near all ones
		for (e = 0; e < 4; e++)
		begin
			wr(4'h9, 8'h1F);
			wr(4'hA, 8'h01 | 8'(e << 1));
			if (e < 2)
				wait_pulse;
			else
				repeat (40) @(posedge clock);
			wr(4'hA, 8'h00);
			rd(4'h9);
			check("after underflow", v & (e < 2 ? 8'hF0 : 8'hFF), e == 1 ? 8'h10 : (e == 0 ? 8'hF0 : 8'h00));
			rd(4'h9);
			check("held count", v & (e < 2 ? 8'hF0 : 8'hFF), e == 1 ? 8'h10 : (e == 0 ? 8'hF0 : 8'h00));
		end
		$display("mode test done");
	endtask
	task t_pwm;
		wr(4'hC, 8'h01);
		wr(4'h9, 8'h07);
		for (e = 0; e < 2; e++)
		begin
			wr(4'hA, e ? 8'hC3 : 8'h83);
			repeat (16) @(posedge clock);
			measure(80);
			near("pwm high", highCount, e ? 60 : 20);
		end
		wr(4'hA, 8'h00);
		$display("pwm test done");
	endtask
	task t_buzz;
		wr(4'h9, 8'hFF);
		wr(4'hA, 8'h01);
		for (e = 0; e < 8; e++)
		begin
			wr(4'hE, 8'h80 | 8'(e < 4 ? e : e + 4));
			repeat (4) @(posedge clock);
			measure(64);
			near("buzzer toggles", toggleCount, 64 >> (e % 4));
		end
		wr(4'hE, 8'h00);
		$display("buzzer test done");
	endtask
	task t_clocking;
		wr(4'hA, 8'h00);
		wr(4'hB, 8'h09);
		wr(4'hB, 8'h01);
		wr(4'h9, 8'hFF);
		wr(4'hA, 8'h01);
		repeat (40) @(posedge clock);
		wr(4'hA, 8'h00);
		rd(4'h9);
		check("divided count", v & 8'hFC, 8'hF4);
		for (e = 0; e < 2; e++)
		begin
			wr(4'hB, 8'h28 | 8'(e << 4));
			wr(4'h9, 8'hFF);
			wr(4'hA, 8'h01);
			for (i = 0; i < 7; i++)
			begin
				extPin <= ~extPin;
				repeat (6) @(posedge clock);
			end
			wr(4'hA, 8'h00);
			rd(4'h9);
			check("pin edges", v, e ? 8'hFC : 8'hFB);
			extPin <= 1'b0;
			repeat (6) @(posedge clock);
		end
		$display("clock source test done");
	endtask
	initial
	begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_reset;
		t_modes;
		t_pwm;
		t_buzz;
		t_clocking;
		results;
	end
endmodule
